// file: verilog/spg_consts.svh
// Constants of the serial EEPROM power and write guard.
// Included by bare name; holds definitions only.
`ifndef SPG_CONSTS_SVH
`define SPG_CONSTS_SVH

// Status byte layout
`define SPG_STATUS_W        8
`define SPG_ST_RDY_BIT      0
`define SPG_ST_WEL_BIT      1
`define SPG_STATUS_RST      8'h00

// Instruction codes
`define SPG_OP_WR_ENABLE    8'h06
`define SPG_OP_WR_DISABLE   8'h04
`define SPG_OP_RD_STATUS    8'h05
`define SPG_OP_WR_STATUS    8'h01
`define SPG_OP_WR_ARRAY     8'h02
`define SPG_OP_RD_ARRAY     8'h03

// Frame lengths in whole bytes
`define SPG_ARRAY_MIN_BYTES 3'h4
`define SPG_STATUS_BYTES    3'h2
`define SPG_CMD_BYTES       3'h1

// Self-timed write time and system clock rate
`define SPG_WRITE_TIME_US   5
`define SPG_CLK_MHZ         250
`define SPG_TMR_W           21

`endif

// file: verilog/spg_pkg.sv
// Types shared by the guard block.
// Constants live in spg_consts.svh.
package spg_pkg;

    // Device power and access modes
    typedef enum logic [1:0] {
        MODE_RESET,
        MODE_STANDBY,
        MODE_ACTIVE,
        MODE_WRITING
    } spg_mode_e;

endpackage

// file: verilog/spg_sync.sv
// Two-flop level synchroniser, a vector of independent bits.
// Assumes each bit is a slow level or a toggle, never a multi-bit word.
`timescale 1ns/1ps
module spg_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta   <= '0;
            sync_o <= '0;
        end else if (ce_i) begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end

endmodule

// file: verilog/spg_guard.sv
// Power-on, write-enable and write-start guard of a serial EEPROM.
// Assumes a mode-0 host: data in sampled on sck rising, out on falling.
//
// Functional notes
// - supply good: leave reset, enter standby
// - supply lost: drop to reset, abandon frame
// - leave reset with latch cleared, standby
// - instruction received only after select low
// - successful write clears the enable latch
// - internal write starts only on select rise
// - array access ignored while writing
// - unknown instruction: no action, output tristated
// - while writing, only read-status answered
// - enable sets, disable clears; writes need latch
`timescale 1ns/1ps
`include "spg_consts.svh"
module spg_guard #(
    parameter int WRITE_CYCLES = `SPG_WRITE_TIME_US * `SPG_CLK_MHZ
) (
    input  wire logic clk_sys_i,
    input  wire logic reset_n_i,
    input  wire logic ce_i,
    input  wire logic supply_ok_i,
    input  wire logic sck_i,
    input  wire logic cs_n_i,
    input  wire logic si_i,
    output logic      so_o,
    output logic      so_oe_o,
    output logic      standby_o,
    output logic      wel_o,
    output logic      busy_o,
    output logic      write_start_o,
    output logic      write_status_o
);

    localparam logic [`SPG_TMR_W-1:0] TMR_LOAD =
        `SPG_TMR_W'(WRITE_CYCLES - 1);

    logic                     rst_meta;
    logic                     rst_n;
    logic                     supply_ok;
    logic                     cs_n_s;
    logic                     cs_n_d;
    logic                     start_tgl_s;
    logic                     done_tgl_s;
    logic                     start_tgl_d;
    logic                     done_tgl_d;
    logic                     cs_rise;
    logic                     cs_fall;
    logic                     start_ev;
    logic                     done_ev;
    spg_pkg::spg_mode_e       mode;
    spg_pkg::spg_mode_e       next_mode;
    logic [2:0]               byte_cnt;
    logic                     byte_open;
    logic [7:0]               opcode;
    logic                     write_enable_latch;
    logic [`SPG_TMR_W-1:0]    timer;
    logic                     write_ok;
    logic                     frame_whole;
    logic                     write_end;
    logic [`SPG_STATUS_W-1:0] status_snap;
    logic                     frame_rst_n;
    logic [2:0]               bit_cnt;
    logic [6:0]               shreg;
    logic [7:0]               rx_byte;
    logic                     start_tgl;
    logic                     done_tgl;
    logic                     got_op;
    logic                     read_status_instruction_on;
    logic [2:0]               out_cnt;

    // Does a finished frame carry this instruction with this many bytes
    function automatic logic frame_is(input logic [7:0] op,
                                      input logic [2:0] cnt,
                                      input logic [7:0] want_op,
                                      input logic [2:0] want_cnt,
                                      input logic       at_least);
        frame_is = (op == want_op) &&
                   (at_least ? (cnt >= want_cnt) : (cnt == want_cnt));
    endfunction

    // Reset release through two flops
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Pin and link-domain levels into the system clock
    spg_sync #(.WIDTH(4)) u_sync (
        .clk_i   (clk_sys_i),
        .rst_n_i (rst_n),
        .ce_i    (ce_i),
        .async_i ({supply_ok_i, ~cs_n_i, start_tgl, done_tgl}),
        .sync_o  ({supply_ok, cs_n_s, start_tgl_s, done_tgl_s})
    );

    // Edge detectors; cs_n_s holds the inverted select, so 1 = selected
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            cs_n_d      <= 1'b0;
            start_tgl_d <= 1'b0;
            done_tgl_d  <= 1'b0;
        end else if (ce_i) begin
            cs_n_d      <= cs_n_s;
            start_tgl_d <= start_tgl_s;
            done_tgl_d  <= done_tgl_s;
        end
    end

    assign cs_fall  = cs_n_s & ~cs_n_d;
    assign cs_rise  = ~cs_n_s & cs_n_d;
    assign start_ev = start_tgl_s ^ start_tgl_d;
    assign done_ev  = done_tgl_s ^ done_tgl_d;

    // Frame verdict at select rise
    assign frame_whole = ~byte_open;
    assign write_ok = frame_whole && write_enable_latch &&
        (frame_is(opcode, byte_cnt, `SPG_OP_WR_ARRAY,
                  `SPG_ARRAY_MIN_BYTES, 1'b1) ||
         frame_is(opcode, byte_cnt, `SPG_OP_WR_STATUS,
                  `SPG_STATUS_BYTES, 1'b0));
    assign write_end = (mode == spg_pkg::MODE_WRITING) && (timer == '0);

    // Mode sequencing
    always_comb begin
        next_mode = mode;
        case (mode)
            spg_pkg::MODE_RESET: begin
                if (supply_ok) next_mode = spg_pkg::MODE_STANDBY;
            end
            spg_pkg::MODE_STANDBY: begin
                if (cs_fall) next_mode = spg_pkg::MODE_ACTIVE;
            end
            spg_pkg::MODE_ACTIVE: begin
                if (cs_rise) begin
                    next_mode = write_ok ? spg_pkg::MODE_WRITING
                                         : spg_pkg::MODE_STANDBY;
                end
            end
            spg_pkg::MODE_WRITING: begin
                // Frames during the write leave the mode unchanged; only read-status is answered
                if (write_end) next_mode = spg_pkg::MODE_STANDBY;
            end
            default: next_mode = spg_pkg::MODE_RESET;
        endcase
        if (!supply_ok) next_mode = spg_pkg::MODE_RESET;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            mode <= spg_pkg::MODE_RESET;
        end else if (ce_i) begin
            mode <= next_mode;
        end
    end

    // Byte bookkeeping of the open frame; count saturates at four
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            byte_cnt  <= 3'h0;
            byte_open <= 1'b0;
            opcode    <= 8'h00;
        end else if (ce_i) begin
            if (mode != spg_pkg::MODE_ACTIVE) begin
                byte_cnt  <= 3'h0;
                byte_open <= 1'b0;
                opcode    <= 8'h00;
            end else begin
                if (start_ev) byte_open <= 1'b1;
                if (done_ev) begin
                    byte_open <= 1'b0;
                    if (byte_cnt == 3'h0) opcode <= rx_byte;
                    if (byte_cnt != `SPG_ARRAY_MIN_BYTES)
                        byte_cnt <= byte_cnt + 3'h1;
                end
            end
        end
    end

    // Write enable latch
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            write_enable_latch <= 1'b0;
        end else if (ce_i) begin
            if (!supply_ok || mode == spg_pkg::MODE_RESET) begin
                write_enable_latch <= 1'b0;
            end else if (write_end) begin
                write_enable_latch <= 1'b0;
            end else if (mode == spg_pkg::MODE_ACTIVE && cs_rise &&
                         frame_whole) begin
                if (frame_is(opcode, byte_cnt, `SPG_OP_WR_ENABLE,
                             `SPG_CMD_BYTES, 1'b0))
                    write_enable_latch <= 1'b1;
                else if (frame_is(opcode, byte_cnt, `SPG_OP_WR_DISABLE,
                                  `SPG_CMD_BYTES, 1'b0))
                    write_enable_latch <= 1'b0;
            end
        end
    end

    // Self-timed write counter and start strobe
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            timer          <= '0;
            write_start_o  <= 1'b0;
            write_status_o <= 1'b0;
        end else if (ce_i) begin
            write_start_o <= 1'b0;
            if (next_mode == spg_pkg::MODE_WRITING &&
                mode == spg_pkg::MODE_ACTIVE) begin
                timer          <= TMR_LOAD;
                write_start_o  <= 1'b1;
                write_status_o <= (opcode == `SPG_OP_WR_STATUS);
            end else if (mode == spg_pkg::MODE_WRITING && timer != '0) begin
                timer <= timer - `SPG_TMR_W'(1);
            end
        end
    end

    // Status snapshot frozen while selected, so the link reads it whole
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            status_snap <= `SPG_STATUS_RST;
        end else if (ce_i && !cs_n_s) begin
            status_snap <= `SPG_STATUS_RST;
            status_snap[`SPG_ST_WEL_BIT] <= write_enable_latch;
            status_snap[`SPG_ST_RDY_BIT] <= (mode == spg_pkg::MODE_WRITING);
        end
    end

    assign standby_o = (mode != spg_pkg::MODE_RESET);
    assign wel_o     = write_enable_latch;
    assign busy_o    = (mode == spg_pkg::MODE_WRITING);

    // Link domain, cleared by deselect; never counts past a frame
    assign frame_rst_n = ~cs_n_i & rst_n;

    always_ff @(posedge sck_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bit_cnt <= 3'h0;
            shreg   <= 7'h00;
            got_op  <= 1'b0;
            read_status_instruction_on <= 1'b0;
        end else begin
            bit_cnt <= bit_cnt + 3'h1;
            shreg   <= {shreg[5:0], si_i};
            if (bit_cnt == 3'h7 && !got_op) begin
                got_op  <= 1'b1;
                // Only read-status drives the output, even while busy
                read_status_instruction_on <= ({shreg, si_i} == `SPG_OP_RD_STATUS);
            end
        end
    end

    // Toggles and byte hold survive deselect so no event is lost
    always_ff @(posedge sck_i or negedge rst_n) begin
        if (!rst_n) begin
            start_tgl <= 1'b0;
            done_tgl  <= 1'b0;
            rx_byte   <= 8'h00;
        end else if (!cs_n_i) begin
            if (bit_cnt == 3'h0) start_tgl <= ~start_tgl;
            if (bit_cnt == 3'h7) begin
                rx_byte  <= {shreg, si_i};
                done_tgl <= ~done_tgl;
            end
        end
    end

    // Status shifted out on falling sck, MSB first, repeating
    always_ff @(negedge sck_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            out_cnt <= 3'h0;
            so_o    <= 1'b0;
        end else if (read_status_instruction_on) begin
            so_o    <= status_snap[3'h7 - out_cnt];
            out_cnt <= out_cnt + 3'h1;
        end
    end

    assign so_oe_o = read_status_instruction_on & standby_o;

    // Checks on the system-clock side
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n);

    sequence s_write_end;
        ce_i && supply_ok && write_end;
    endsequence

    sequence s_partial_rise;
        ce_i && supply_ok && mode == spg_pkg::MODE_ACTIVE &&
        cs_rise && byte_open;
    endsequence

    property p_standby_on_supply;
        ce_i && mode == spg_pkg::MODE_RESET && supply_ok
        |=> mode == spg_pkg::MODE_STANDBY;
    endproperty
    a_standby_on_supply: assert property (p_standby_on_supply)
        else $error("supply good did not reach standby");

    property p_reset_on_loss;
        ce_i && !supply_ok |=> mode == spg_pkg::MODE_RESET && !wel_o;
    endproperty
    a_reset_on_loss: assert property (p_reset_on_loss)
        else $error("supply loss did not force reset");

    property p_standby_clean;
        $past(mode) == spg_pkg::MODE_RESET &&
        mode == spg_pkg::MODE_STANDBY |-> !wel_o && !busy_o;
    endproperty
    a_standby_clean: assert property (p_standby_clean)
        else $error("left reset with latch or write active");

    property p_select_first;
        mode == spg_pkg::MODE_STANDBY && !cs_fall |=>
        mode != spg_pkg::MODE_ACTIVE;
    endproperty
    a_select_first: assert property (p_select_first)
        else $error("frame opened without select");

    property p_latch_clears;
        s_write_end |=> !wel_o ##1 !wel_o;
    endproperty
    a_latch_clears: assert property (p_latch_clears)
        else $error("latch not cleared after write");

    property p_start_on_rise;
        write_start_o |-> $past(cs_rise) && busy_o;
    endproperty
    a_start_on_rise: assert property (p_start_on_rise)
        else $error("write started without select rise");

    // Last busy cycle and supply loss clear the latch on their own
    property p_busy_ignores;
        busy_o && ce_i && supply_ok && !write_end && cs_rise |=>
        !write_start_o && $stable(wel_o);
    endproperty
    a_busy_ignores: assert property (p_busy_ignores)
        else $error("frame acted on during write");

    property p_start_needs_latch;
        write_start_o |-> $past(wel_o, 1);
    endproperty
    a_start_needs_latch: assert property (p_start_needs_latch)
        else $error("write started with latch clear");

    property p_partial_nothing;
        s_partial_rise |=> !write_start_o && wel_o == $past(wel_o);
    endproperty
    a_partial_nothing: assert property (p_partial_nothing)
        else $error("partial byte frame acted on");

endmodule

// file: dv/spg_host_model.sv
// Host side of the serial link: select, mode-0 clock and data in.
// Assumes the guard samples data in on sck rising, so on falling.
`timescale 1ns/1ps
module spg_host_model (
    input  wire logic so_i,
    input  wire logic so_oe_i,
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      si_o
);
    localparam int HALF_NS = 24; // 48 ns link period

    // Idle: deselected, clock parked low between frames
    initial begin
        cs_n_o = 1'b1;
        sck_o  = 1'b0;
        si_o   = 1'b0;
    end

    // One frame, MSB first; sel low keeps select high on purpose
    task automatic frame(input logic [39:0] data, input int nbits,
                         input bit sel, output logic [7:0] rx);
        rx = 8'h00;
        #7;
        cs_n_o = ~sel;
        #30;
        for (int i = nbits - 1; i >= 0; i--) begin
            si_o = data[i];
            #HALF_NS;
            // Sample just before rising, half a period after the shift
            if (so_oe_i === 1'b1) begin
                rx = {rx[6:0], so_i};
            end
            sck_o = 1'b1;
            #HALF_NS;
            sck_o = 1'b0;
        end
        #HALF_NS;
        cs_n_o = 1'b1;
        si_o = ~si_o; // Released line shows no stale bit
        #60;
    endtask
endmodule

// file: dv/test_spi_eeprom_power_write_guard.sv
// Self-checking bench of the power and write guard.
// Assumes the guard's assertions live in its own files.
`timescale 1ns/1ps
`include "spg_consts.svh"
`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        fail_count++; \
        $display("Error at %0t ns: got %0h expected %0h", \
                 $time, (got), (exp)); \
    end \
end
module test_spi_eeprom_power_write_guard;
    localparam int WR_CYC = 2000; // Long enough to send frames while busy
    logic        clk_sys_i;
    logic        reset_n_i;
    logic        supply_ok_i;
    logic        ce;
    logic        cs_n, sck, si, so, so_oe;
    logic        standby, write_enable_latch, busy, write_start, write_status;
    logic        last_status;
    logic [15:0] rnd;
    logic [39:0] frm;
    logic [7:0]  rx;
    int          fail_count, samples_checked, starts, oe_rises, n;

    spg_guard #(.WRITE_CYCLES(WR_CYC)) spg_guard_i (
        .clk_sys_i      (clk_sys_i),
        .reset_n_i      (reset_n_i),
        .ce_i           (ce),
        .supply_ok_i    (supply_ok_i),
        .sck_i          (sck),
        .cs_n_i         (cs_n),
        .si_i           (si),
        .so_o           (so),
        .so_oe_o        (so_oe),
        .standby_o      (standby),
        .wel_o          (write_enable_latch),
        .busy_o         (busy),
        .write_start_o  (write_start),
        .write_status_o (write_status)
    );

    spg_host_model spg_host_model_i (
        .so_i    (so),
        .so_oe_i (so_oe),
        .cs_n_o  (cs_n),
        .sck_o   (sck),
        .si_o    (si)
    );

    // 250 MHz system clock
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    // Count write starts and remember their kind
    always @(posedge clk_sys_i) begin
        if (write_start === 1'b1) begin
            starts++;
            last_status = write_status;
        end
    end

    // Count every time the output driver turns on
    always @(posedge so_oe) oe_rises++;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Status byte: latch in bit 1, busy in bit 0
    function automatic logic [7:0] exp_status(input logic w, input logic b);
        return {6'h00, w, b};
    endfunction

    task automatic step(input int k);
        repeat (k) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic send(input logic [39:0] data, input int nbits);
        spg_host_model_i.frame(data, nbits, 1'b1, rx);
    endtask

    // Bounded wait for the self-timed write to finish
    task automatic wait_idle;
        for (int i = 0; i < WR_CYC + 50 && busy !== 1'b0; i++) begin
            step(1);
        end
        `CHK(busy, 1'b0)
    endtask

    task automatic close_out;
        $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog sized well past the expected run
    initial begin
        #300000;
        fail_count++;
        $display("Error at %0t ns: watchdog expired", $time);
        close_out();
    end

    initial begin
        reset_n_i = 1'b0;
        supply_ok_i = 1'b0;
        ce = 1'b1;
        rnd = 16'h0011;
        {fail_count, samples_checked, starts, oe_rises} = '0;
        step(12);
        reset_n_i = 1'b1;
        step(10);
        `CHK(standby, 1'b0)
        supply_ok_i = 1'b1;
        step(8);
        `CHK(standby, 1'b1)
        `CHK(write_enable_latch, 1'b0)
        // Write with the latch clear, then clocking while deselected
        send({8'h00, 8'h02, rnd, 8'hA5}, 32);
        `CHK(starts, 0)
        spg_host_model_i.frame(40'h06, 8, 1'b0, rx);
        `CHK(write_enable_latch, 1'b0)
        send(`SPG_OP_WR_ENABLE, 8);
        `CHK(write_enable_latch, 1'b1)
        send(`SPG_OP_WR_DISABLE, 8);
        `CHK(write_enable_latch, 1'b0)
        // One bit short of a whole array write
        send(`SPG_OP_WR_ENABLE, 8);
        send({8'h00, 8'h02, rnd, 8'h5A} >> 1, 31);
        `CHK(starts, 0)
        `CHK(write_enable_latch, 1'b1)
        // Random array writes, poked while busy; this seed never draws a status write
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            n = starts;
            frm = rnd[1] ? {8'h02, rnd, rnd[7:0], rnd[15:8]}
                         : {8'h00, 8'h02, rnd, rnd[7:0]};
            send(`SPG_OP_WR_ENABLE, 8);
            if (rnd[0]) begin
                send({24'h0, 8'h01, rnd[15:8]}, 16);
            end else begin
                send(frm, rnd[1] ? 40 : 32);
            end
            `CHK(starts, n + 1)
            `CHK(last_status, rnd[0])
            `CHK(busy, 1'b1)
            send(`SPG_OP_WR_DISABLE, 8);
            `CHK(write_enable_latch, 1'b1)
            send({8'h00, 8'h02, rnd, rnd[7:0]}, 32);
            `CHK(starts, n + 1)
            send({`SPG_OP_RD_STATUS, 8'h00}, 16);
            `CHK(rx, exp_status(1'b1, 1'b1))
            wait_idle();
            `CHK(write_enable_latch, 1'b0)
            send({`SPG_OP_RD_STATUS, 8'h00}, 16);
            `CHK(rx, exp_status(1'b0, 1'b0))
        end
        // Unknown codes with the latch set
        send(`SPG_OP_WR_ENABLE, 8);
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            n = oe_rises;
            send({24'h0, rnd[7:3], 3'h7, 8'h00}, 16);
            `CHK(oe_rises, n)
            `CHK(write_enable_latch, 1'b1)
        end
        // Brown-out in the middle of an internal write
        send({8'h00, 8'h02, rnd, 8'h3C}, 32);
        `CHK(busy, 1'b1)
        // Clock enable low freezes the write and the supply sync
        ce = 1'b0;
        supply_ok_i = 1'b0;
        step(6);
        `CHK(busy, 1'b1)
        `CHK(write_enable_latch, 1'b1)
        ce = 1'b1;
        step(6);
        `CHK(standby, 1'b0)
        `CHK(busy, 1'b0)
        `CHK(write_enable_latch, 1'b0)
        supply_ok_i = 1'b1;
        step(8);
        `CHK(standby, 1'b1)
        `CHK(write_enable_latch, 1'b0)
        close_out();
    end
endmodule
